// ===== core/gpio_trigger_pkg.sv
package gpio_trigger_pkg;

   // Register byte addresses
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  ADDR_CONFIG     = 8'h00;
   localparam logic [7:0]  ADDR_SW_CMD     = 8'h04;
   localparam logic [7:0]  ADDR_STATUS     = 8'h08;
   localparam logic [7:0]  ADDR_UNLOCK     = 8'h0C;

   // Configuration layout, matches pin_cfg_t packing
   localparam int          CFG_W           = 14;
   localparam logic [13:0] CFG_RESET       = 14'h0000;

   // Input function codes
   localparam logic [3:0]  GPI_FUNC_GEN    = 4'h9;
   localparam logic [3:0]  GPI_MARGIN      = 4'hA;
   localparam logic [3:0]  GPI_RESET       = 4'hB;
   localparam logic [3:0]  GPI_NVM         = 4'hC;
   localparam logic [3:0]  GPI_LOCK        = 4'hD;

   // Output flag codes
   localparam logic [3:0]  GPO_NONVOLATILE_WRITE_IN_PROGRESS    = 4'h1;
   localparam logic [3:0]  GPO_BUSY_FIRST  = 4'h4;
   localparam logic [3:0]  GPO_BUSY_LAST   = 4'h7;
   localparam logic [3:0]  GPO_WIN_FIRST   = 4'h8;
   localparam logic [3:0]  GPO_WIN_LAST    = 4'hB;

   // Software command bit positions
   localparam int          SW_START_LSB    = 0;
   localparam int          SW_STOP_LSB     = 4;
   localparam int          SW_MLOW_LSB     = 8;
   localparam int          SW_MHIGH_LSB    = 12;
   localparam int          SW_NVM_ALLOW    = 16;
   localparam int          SW_NVM_BLOCK    = 17;
   localparam int          SW_LOCK         = 18;
   localparam int          UNLOCK_BIT      = 0;

   // Reset values of control state
   localparam logic        NVM_ALLOW_RESET = 1'b1;
   localparam logic        LOCK_RESET      = 1'b0;

   // Cycles from reset release until the synchronised level is trusted
   localparam int          SYNC_STAGES     = 2;
   localparam logic [1:0]  BOOT_SETTLE     = 2'(SYNC_STAGES + 1);

   typedef struct packed {
      logic       pin_output_enable;
      logic [3:0] pin_output_flag_code;
      logic [3:0] pin_channel_select;
      logic [3:0] pin_input_function_code;
      logic       pin_input_enable;
   } pin_cfg_t;

   typedef struct packed {
      logic [3:0] start;
      logic [3:0] stop;
      logic [3:0] margin_low;
      logic [3:0] margin_high;
   } chan_cmd_t;

   typedef struct packed {
      logic       nonvolatile_write_in_progress;
      logic [3:0] channel_busy;
      logic [3:0] window_result;
   } dev_flags_t;

   typedef struct packed {
      logic valid;
      logic two_wire;
      logic to_lock_release;
      logic to_soft_reset;
   } serial_wr_t;

   typedef struct packed {
      logic [31:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } apb_req_t;

endpackage

// ===== core/pin_edge_detect.sv
`timescale 1ns/1ns
`default_nettype none

// Two-stage synchroniser with edge detection on the settled stage
module pin_edge_detect
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);

   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
   } sync_state_t;

   sync_state_t s;
   sync_state_t next_s;

   // Meta stage feeds only the second stage
   always_comb
   begin
      next_s      = s;
      next_s.meta = pin_in;
      next_s.sync = s.meta;
      next_s.prev = s.sync;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s <= '0;
      else
         s <= next_s;
   end

   // Edges come only from settled stages
   assign level = s.sync;
   assign rise  = s.sync & ~s.prev;
   assign fall  = ~s.sync & s.prev;

endmodule

`default_nettype wire

// ===== core/gpio_function_trigger_map.sv
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module gpio_function_trigger_map
#(
   parameter int CHANNELS = 4
)
(
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic [31:0]                   paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [31:0]                   pwdata,
   output logic [31:0]                        prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          gpio_in,
   output logic                               gpio_out,
   output logic                               gpio_oe,
   input  wire gpio_trigger_pkg::dev_flags_t  dev_flags,
   input  wire gpio_trigger_pkg::serial_wr_t  serial_wr,
   output logic                               serial_wr_accept,
   output gpio_trigger_pkg::chan_cmd_t        chan_cmd,
   output logic                               device_reset_req,
   output logic                               nvm_program_allowed,
   output logic                               register_map_locked
);

   // The function codes name exactly four channels
   generate
      if (CHANNELS != 4)
      begin : g_bad_channels
         $error("CHANNELS must be 4");
      end
   endgenerate

   typedef enum logic [2:0] {
      BOOT_SETTLE = 3'b001,
      BOOT_APPLY  = 3'b010,
      RUNNING     = 3'b100
   } boot_state_t;

   typedef struct packed {
      boot_state_t                 phase;
      logic [1:0]                  settle_cnt;
      gpio_trigger_pkg::pin_cfg_t  cfg;
      gpio_trigger_pkg::chan_cmd_t cmd;
      logic [3:0]                  func_running;
      logic [3:0]                  margin_high_sel;
      logic                        reset_req;
      logic                        nvm_allowed;
      logic                        locked;
      logic                        pin_drive;
      logic [31:0]                 rdata;
   } state_t;

   state_t                       s;
   state_t                       next_s;
   gpio_trigger_pkg::apb_req_t   req;
   logic                         pin_level;
   logic                         pin_rise;
   logic                         pin_fall;

   // Selects one status flag for the output direction
   function automatic logic flag_select(input logic [3:0] code,
                                        input gpio_trigger_pkg::dev_flags_t f);
      logic r;
      r = 1'b0;
      if (code == gpio_trigger_pkg::GPO_NONVOLATILE_WRITE_IN_PROGRESS)
         r = f.nonvolatile_write_in_progress;
      else if (code >= gpio_trigger_pkg::GPO_BUSY_FIRST &&
               code <= gpio_trigger_pkg::GPO_BUSY_LAST)
         r = f.channel_busy[code[1:0]];
      else if (code >= gpio_trigger_pkg::GPO_WIN_FIRST &&
               code <= gpio_trigger_pkg::GPO_WIN_LAST)
         r = f.window_result[code[1:0]];
      return r;
   endfunction

   // Decodes which register a bus address hits
   function automatic logic addr_is(input logic [31:0] a, input logic [7:0] off);
      return a[31:gpio_trigger_pkg::ADDR_W] == '0 &&
             a[gpio_trigger_pkg::ADDR_W-1:0] == off;
   endfunction

   pin_edge_detect u_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  (gpio_in),
      .level   (pin_level),
      .rise    (pin_rise),
      .fall    (pin_fall)
   );

   assign req = '{paddr: paddr, psel: psel, penable: penable,
                  pwrite: pwrite, pwdata: pwdata};

   // Locked map refuses software writes except the release register
   logic mapped;
   logic wr_access;
   logic wr_blocked;

   always_comb
   begin
      mapped     = addr_is(req.paddr, gpio_trigger_pkg::ADDR_CONFIG) ||
                   addr_is(req.paddr, gpio_trigger_pkg::ADDR_SW_CMD) ||
                   addr_is(req.paddr, gpio_trigger_pkg::ADDR_STATUS) ||
                   addr_is(req.paddr, gpio_trigger_pkg::ADDR_UNLOCK);
      wr_access  = req.psel && req.penable && req.pwrite && mapped;
      wr_blocked = s.locked &&
                   !addr_is(req.paddr, gpio_trigger_pkg::ADDR_UNLOCK);
   end

   // Serial writes honour the pin lock with two exceptions
   always_comb
   begin
      serial_wr_accept = serial_wr.valid &&
                         (!s.locked || serial_wr.to_lock_release ||
                          (serial_wr.to_soft_reset && serial_wr.two_wire));
   end

   // Pin event source: real edges once running, level at power-up
   logic       ev_rise;
   logic       ev_fall;
   logic       pin_is_input;
   logic [3:0] code;
   logic [3:0] sel;

   always_comb
   begin
      pin_is_input = s.cfg.pin_input_enable;
      code         = s.cfg.pin_input_function_code;
      sel          = s.cfg.pin_channel_select;
      ev_rise      = 1'b0;
      ev_fall      = 1'b0;
      if (pin_is_input)
      begin
         unique case (s.phase)
            BOOT_SETTLE:
            begin
               ev_rise = 1'b0;
               ev_fall = 1'b0;
            end
            BOOT_APPLY:
            begin
               ev_rise = pin_level;
               ev_fall = !pin_level;
            end
            RUNNING:
            begin
               ev_rise = pin_rise;
               ev_fall = pin_fall;
            end
            default:
            begin
               ev_rise = 1'b0;
               ev_fall = 1'b0;
            end
         endcase
      end
   end

   // Software commands, masked where the pin owns the function
   logic       sw_wr;
   logic [3:0] sw_start;
   logic [3:0] sw_stop;
   logic [3:0] sw_mlow;
   logic [3:0] sw_mhigh;
   logic       sw_nvm_allow;
   logic       sw_nvm_block;
   logic       sw_lock;
   logic       pin_owns_gen;
   logic       pin_owns_margin;
   logic       pin_owns_nvm;
   logic       pin_owns_lock;

   always_comb
   begin
      sw_wr           = wr_access && !wr_blocked &&
                        addr_is(req.paddr, gpio_trigger_pkg::ADDR_SW_CMD);
      pin_owns_gen    = pin_is_input && code == gpio_trigger_pkg::GPI_FUNC_GEN;
      pin_owns_margin = pin_is_input && code == gpio_trigger_pkg::GPI_MARGIN;
      pin_owns_nvm    = pin_is_input && code == gpio_trigger_pkg::GPI_NVM;
      pin_owns_lock   = pin_is_input && code == gpio_trigger_pkg::GPI_LOCK;
      sw_start        = pin_owns_gen ? 4'h0 :
                        req.pwdata[gpio_trigger_pkg::SW_START_LSB +: 4];
      sw_stop         = pin_owns_gen ? 4'h0 :
                        req.pwdata[gpio_trigger_pkg::SW_STOP_LSB +: 4];
      sw_mlow         = pin_owns_margin ? 4'h0 :
                        req.pwdata[gpio_trigger_pkg::SW_MLOW_LSB +: 4];
      sw_mhigh        = pin_owns_margin ? 4'h0 :
                        req.pwdata[gpio_trigger_pkg::SW_MHIGH_LSB +: 4];
      sw_nvm_allow    = !pin_owns_nvm && req.pwdata[gpio_trigger_pkg::SW_NVM_ALLOW];
      sw_nvm_block    = !pin_owns_nvm && req.pwdata[gpio_trigger_pkg::SW_NVM_BLOCK];
      sw_lock         = !pin_owns_lock && req.pwdata[gpio_trigger_pkg::SW_LOCK];
      if (!sw_wr)
      begin
         sw_start     = 4'h0;
         sw_stop      = 4'h0;
         sw_mlow      = 4'h0;
         sw_mhigh     = 4'h0;
         sw_nvm_allow = 1'b0;
         sw_nvm_block = 1'b0;
         sw_lock      = 1'b0;
      end
   end

   // Next state: boot sequencing, pin actions, bus writes, read data
   always_comb
   begin
      next_s           = s;
      next_s.cmd       = '0;
      next_s.reset_req = 1'b0;

      // Boot sequence waits for the synchroniser to fill
      unique case (s.phase)
         BOOT_SETTLE:
         begin
            next_s.settle_cnt = s.settle_cnt + 2'h1;
            if (s.settle_cnt == gpio_trigger_pkg::BOOT_SETTLE - 2'h1)
               next_s.phase = BOOT_APPLY;
         end
         BOOT_APPLY:
            next_s.phase = RUNNING;
         RUNNING:
            next_s.phase = RUNNING;
         default:
            next_s.phase = BOOT_SETTLE;
      endcase

      // Pin-driven actions; other codes fall through untouched
      if (code == gpio_trigger_pkg::GPI_FUNC_GEN)
      begin
         if (ev_rise)
            next_s.cmd.start = sel;
         if (ev_fall)
            next_s.cmd.stop = sel;
      end
      else if (code == gpio_trigger_pkg::GPI_MARGIN)
      begin
         if (ev_fall)
            next_s.cmd.margin_low = sel;
         if (ev_rise)
            next_s.cmd.margin_high = sel;
      end
      else if (code == gpio_trigger_pkg::GPI_RESET)
      begin
         // Only a real falling edge counts; a low level at boot
         // would otherwise hold the device in reset forever
         if (ev_fall && s.phase == RUNNING)
            next_s.reset_req = 1'b1;
      end
      else if (code == gpio_trigger_pkg::GPI_NVM)
      begin
         if (ev_fall)
            next_s.nvm_allowed = 1'b1;
         if (ev_rise)
            next_s.nvm_allowed = 1'b0;
      end
      else if (code == gpio_trigger_pkg::GPI_LOCK)
      begin
         if (ev_fall)
            next_s.locked = 1'b0;
         if (ev_rise)
            next_s.locked = 1'b1;
      end
      // Remaining codes: no action on any edge or level

      // Software commands merge with pin commands
      next_s.cmd.start       = next_s.cmd.start | sw_start;
      next_s.cmd.stop        = next_s.cmd.stop | sw_stop;
      next_s.cmd.margin_low  = next_s.cmd.margin_low | sw_mlow;
      next_s.cmd.margin_high = next_s.cmd.margin_high | sw_mhigh;
      if (sw_nvm_allow)
         next_s.nvm_allowed = 1'b1;
      if (sw_nvm_block)
         next_s.nvm_allowed = 1'b0;
      if (sw_lock)
         next_s.locked = 1'b1;

      // Release clears the lock from either path
      if ((wr_access && addr_is(req.paddr, gpio_trigger_pkg::ADDR_UNLOCK) &&
           req.pwdata[gpio_trigger_pkg::UNLOCK_BIT]) ||
          (serial_wr_accept && serial_wr.to_lock_release))
         next_s.locked = 1'b0;

      // Configuration write
      if (wr_access && !wr_blocked &&
          addr_is(req.paddr, gpio_trigger_pkg::ADDR_CONFIG))
         next_s.cfg = gpio_trigger_pkg::pin_cfg_t'(req.pwdata[gpio_trigger_pkg::CFG_W-1:0]);

      // Tracked channel state for status readback
      next_s.func_running    = (s.func_running | next_s.cmd.start) & ~next_s.cmd.stop;
      next_s.margin_high_sel = (s.margin_high_sel | next_s.cmd.margin_high) &
                               ~next_s.cmd.margin_low;

      // Output flag sampled each cycle
      next_s.pin_drive = flag_select(s.cfg.pin_output_flag_code, dev_flags);

      // Read data captured in the setup phase
      if (req.psel && !req.penable)
      begin
         next_s.rdata = 32'h0000_0000;
         if (addr_is(req.paddr, gpio_trigger_pkg::ADDR_CONFIG))
            next_s.rdata = {18'h0, s.cfg};
         else if (addr_is(req.paddr, gpio_trigger_pkg::ADDR_STATUS))
            next_s.rdata = {19'h0, s.phase == RUNNING, s.pin_drive, pin_level,
                            s.locked, s.nvm_allowed, s.margin_high_sel, s.func_running};
         else if (addr_is(req.paddr, gpio_trigger_pkg::ADDR_UNLOCK))
            next_s.rdata = {31'h0, s.locked};
      end
   end

   // Single state register; power-up leaves the pin unmapped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s                 <= '0;
         s.phase           <= BOOT_SETTLE;
         s.cfg             <= gpio_trigger_pkg::CFG_RESET;
         s.nvm_allowed     <= gpio_trigger_pkg::NVM_ALLOW_RESET;
         s.locked          <= gpio_trigger_pkg::LOCK_RESET;
      end
      else
         s <= next_s;
   end

   // Zero-wait slave; unmapped accesses or locked writes report an error
   assign pready              = 1'b1;
   assign pslverr             = psel && penable &&
                                (!mapped || (pwrite && wr_blocked));
   assign prdata              = s.rdata;
   assign chan_cmd            = s.cmd;
   assign device_reset_req    = s.reset_req;
   assign nvm_program_allowed = s.nvm_allowed;
   assign register_map_locked = s.locked;

   // Input enable wins when both direction bits are set
   assign gpio_out            = s.pin_drive;
   assign gpio_oe             = s.cfg.pin_output_enable && !s.cfg.pin_input_enable;

endmodule

`default_nettype wire

// ===== sim/gpio_trigger_sva.sv
`timescale 1ns/1ns
`default_nettype none
module gpio_trigger_sva
#(
   parameter int CHANNELS = 4
)
(
   input wire logic                         pclk,
   input wire logic                         presetn,
   input wire logic [31:0]                  paddr,
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic                         pwrite,
   input wire logic [31:0]                  pwdata,
   input wire logic                         pslverr,
   input wire logic                         gpio_in,
   input wire logic                         gpio_out,
   input wire logic                         gpio_oe,
   input wire gpio_trigger_pkg::dev_flags_t dev_flags,
   input wire gpio_trigger_pkg::serial_wr_t serial_wr,
   input wire logic                         serial_wr_accept,
   input wire gpio_trigger_pkg::chan_cmd_t  chan_cmd,
   input wire logic                         device_reset_req,
   input wire logic                         register_map_locked
);
   gpio_trigger_pkg::pin_cfg_t cfg;
   logic [3:0]                 up;
   logic [3:0]                 code;
   logic [3:0]                 sel;
   logic                       flag;
   logic                       armed;

   // Shadow of the accepted configuration, refused writes leave it alone
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg <= gpio_trigger_pkg::CFG_RESET;
         up  <= 4'h0;
      end
      else
      begin
         if (psel && penable && pwrite && !pslverr && paddr[7:0] == gpio_trigger_pkg::ADDR_CONFIG)
            cfg <= pwdata[13:0];
         if (up != 4'hF)
            up <= up + 4'h1;
      end
   end

   // Flag the output code selects; unassigned codes give 0
   always_comb
   begin
      flag = 1'h0;
      if (cfg.pin_output_flag_code == gpio_trigger_pkg::GPO_NONVOLATILE_WRITE_IN_PROGRESS)
         flag = dev_flags.nonvolatile_write_in_progress;
      else if (cfg.pin_output_flag_code[3:2] == 2'h1)
         flag = dev_flags.channel_busy[cfg.pin_output_flag_code[1:0]];
      else if (cfg.pin_output_flag_code[3:2] == 2'h2)
         flag = dev_flags.window_result[cfg.pin_output_flag_code[1:0]];
   end

   // Edge checks wait until the boot level action is long over
   assign armed = cfg.pin_input_enable && up == 4'hF;
   assign code  = cfg.pin_input_function_code;
   assign sel   = cfg.pin_channel_select;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_accept_filter: assert property (serial_wr_accept == (serial_wr.valid && (!register_map_locked
      || serial_wr.to_lock_release || (serial_wr.to_soft_reset && serial_wr.two_wire))))
      else $error("serial write filter wrong");
   a_release_unlocks: assert property (serial_wr.valid && serial_wr.to_lock_release
      |=> !register_map_locked) else $error("release did not unlock");
   a_oe_direction: assert property (gpio_oe == (cfg.pin_output_enable && !cfg.pin_input_enable))
      else $error("pin direction wrong");
   a_flag_drive: assert property (gpio_oe && $stable(cfg) |-> gpio_out == $past(flag))
      else $error("pin flag wrong");
   a_start_rise: assert property (armed && $rose(gpio_in) && code == gpio_trigger_pkg::GPI_FUNC_GEN
      |-> ##[1:5] chan_cmd.start == sel) else $error("no start pulse");
   a_low_fall: assert property (armed && $fell(gpio_in) && code == gpio_trigger_pkg::GPI_MARGIN
      |-> ##[1:5] chan_cmd.margin_low == sel) else $error("no margin low pulse");
   a_lock_rise: assert property (armed && $rose(gpio_in) && code == gpio_trigger_pkg::GPI_LOCK
      |-> ##[1:5] register_map_locked) else $error("map not locked");
   a_reset_single: assert property (device_reset_req |=> !device_reset_req [*4])
      else $error("reset request repeated");
endmodule

bind gpio_function_trigger_map gpio_trigger_sva #(.CHANNELS(CHANNELS)) gpio_trigger_sva_inst
(
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .pslverr(pslverr), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
   .dev_flags(dev_flags), .serial_wr(serial_wr), .serial_wr_accept(serial_wr_accept),
   .chan_cmd(chan_cmd), .device_reset_req(device_reset_req), .register_map_locked(register_map_locked)
);
`default_nettype wire

// ===== sim/pin_partner.sv
`timescale 1ns/1ns
`default_nettype none
module pin_partner
(
   input  wire logic drive,
   input  wire logic level,
   input  wire logic gpio_out,
   input  wire logic gpio_oe,
   output logic      pin
);
   // Device wins while it drives; an idle line rests on its pull-up
   assign pin = gpio_oe ? gpio_out : (drive ? level : 1'h1);
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic                         pclk;
   logic                         presetn;
   logic [31:0]                  paddr;
   logic                         psel;
   logic                         penable;
   logic                         pwrite;
   logic [31:0]                  pwdata;
   logic [31:0]                  prdata;
   logic                         pready;
   logic                         pslverr;
   logic                         gpio_in;
   logic                         gpio_out;
   logic                         gpio_oe;
   gpio_trigger_pkg::dev_flags_t flags;
   gpio_trigger_pkg::serial_wr_t swr;
   logic                         accept;
   gpio_trigger_pkg::chan_cmd_t  cmd;
   gpio_trigger_pkg::chan_cmd_t  acc;
   logic                         rst_req;
   logic                         nvm_ok;
   logic                         locked;
   logic                         drive;
   logic                         level;
   logic [31:0]                  r;
   logic [3:0]                   ocode [9] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB};
   int                           obit [9]  = '{8, 4, 5, 6, 7, 0, 1, 2, 3};
   logic [3:0]                   icode [4] = '{4'h0, 4'h8, 4'hE, 4'hF};
   int                           failures;
   int                           comparisons;
   int                           cycles;
   int                           rcnt;

   gpio_function_trigger_map #(.CHANNELS(4)) gpio_function_trigger_map_inst
   (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio_in(gpio_in),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .dev_flags(flags), .serial_wr(swr), .serial_wr_accept(accept),
      .chan_cmd(cmd), .device_reset_req(rst_req), .nvm_program_allowed(nvm_ok), .register_map_locked(locked)
   );

   pin_partner pin_partner_inst
   (
      .drive(drive), .level(level), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin(gpio_in)
   );

   // Clock at 25 MHz
   initial
   begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end

   // Hang guard, the run needs well under a thousand cycles
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [31:0] cfg(input logic oe, input logic [3:0] oc, sel, ic, input logic ie);
      return {18'h0, oe, oc, sel, ic, ie};
   endfunction

   // One bus transfer; answer taken at the edge that sees pready
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic err);
      // Idle edge after a transfer that just ended, so psel is set once per step
      if (psel === 1'h1)
         @(posedge pclk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1)
         @(posedge pclk);
      r = prdata;
      check("pslverr", {31'h0, err}, {31'h0, pslverr});
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   // Collects the one-cycle pulses, sampled once each cycle has settled
   task automatic obs(input int n);
      repeat (n)
      begin
         #1;
         acc = acc | cmd;
         if (rst_req === 1'h1)
            rcnt++;
         @(posedge pclk);
      end
   endtask

   task automatic pin(input logic lvl, input int n);
      acc = '0;
      rcnt = 0;
      drive <= 1'h1;
      level <= lvl;
      obs(n);
   endtask

   task automatic ser(input logic [3:0] s, input logic exp);
      swr <= s;
      #1;
      check("accept", {31'h0, exp}, {31'h0, accept});
      @(posedge pclk);
   endtask

   // Main sequence
   initial
   begin
      presetn = 1'h0;
      paddr   = 32'h0;
      psel    = 1'h0;
      penable = 1'h0;
      pwrite  = 1'h0;
      pwdata  = 32'h0;
      flags   = '0;
      swr     = '0;
      drive   = 1'h0;
      level   = 1'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      // Config lands before the boot cycle that applies the pin level
      xfer(1'h1, 32'h0, cfg(1'h0, 4'h0, 4'h5, gpio_trigger_pkg::GPI_FUNC_GEN, 1'h1), 1'h0);
      pin(1'h1, 8);
      check("boot start", 32'h5, 32'(acc.start));
      xfer(1'h0, 32'(gpio_trigger_pkg::ADDR_STATUS), 32'h0, 1'h0);
      check("status", 32'h1505, r);
      xfer(1'h0, 32'h10, 32'h0, 1'h1);
      check("unmapped", 32'h0, r);
      pin(1'h0, 8);
      check("stop", 32'h5, 32'(acc.stop));
      pin(1'h1, 8);
      check("start", 32'h5, 32'(acc.start));
      xfer(1'h1, 32'(gpio_trigger_pkg::ADDR_SW_CMD), 32'h5, 1'h0);
      pin(1'h1, 4);
      check("sw start masked", 32'h0, 32'(acc.start));
      xfer(1'h1, 32'h0, cfg(1'h0, 4'h0, 4'h5, gpio_trigger_pkg::GPI_MARGIN, 1'h1), 1'h0);
      pin(1'h0, 8);
      check("margin low", 32'h5, 32'(acc.margin_low));
      pin(1'h1, 8);
      check("margin high", 32'h5, 32'(acc.margin_high));
      xfer(1'h1, 32'h0, cfg(1'h0, 4'h0, 4'h0, gpio_trigger_pkg::GPI_RESET, 1'h1), 1'h0);
      pin(1'h0, 6);
      check("reset pulse", 32'h1, rcnt);
      pin(1'h1, 8);
      check("reset on rise", 32'h0, rcnt);
      xfer(1'h1, 32'h0, cfg(1'h0, 4'h0, 4'h0, gpio_trigger_pkg::GPI_NVM, 1'h1), 1'h0);
      pin(1'h1, 4);
      pin(1'h0, 8);
      check("nvm allow", 32'h1, {31'h0, nvm_ok});
      pin(1'h1, 8);
      check("nvm block", 32'h0, {31'h0, nvm_ok});
      pin(1'h0, 8);
      check("nvm allow", 32'h1, {31'h0, nvm_ok});
      xfer(1'h1, 32'h0, cfg(1'h0, 4'h0, 4'h0, gpio_trigger_pkg::GPI_LOCK, 1'h1), 1'h0);
      pin(1'h1, 8);
      check("lock", 32'h1, {31'h0, locked});
      pin(1'h0, 8);
      check("unlock", 32'h0, {31'h0, locked});
      pin(1'h1, 8);
      xfer(1'h1, 32'h0, 32'h2000, 1'h1);
      ser(4'h8, 1'h0);
      ser(4'h9, 1'h0);
      ser(4'hD, 1'h1);
      ser(4'hA, 1'h1);
      swr <= '0;
      obs(1);
      check("released", 32'h0, {31'h0, locked});
      foreach (icode[i])
      begin
         xfer(1'h1, 32'h0, cfg(1'h0, 4'h0, 4'h5, icode[i], 1'h1), 1'h0);
         pin(1'h0, 8);
         check("idle code fall", 32'h0, 32'(acc) | rcnt);
         pin(1'h1, 8);
         check("idle code rise", 32'h0, 32'(acc) | rcnt | {31'h0, locked});
      end
      xfer(1'h1, 32'(gpio_trigger_pkg::ADDR_SW_CMD), 32'h5, 1'h0);
      pin(1'h1, 4);
      check("sw start", 32'h5, 32'(acc.start));
      drive <= 1'h0;
      foreach (ocode[i])
      begin
         xfer(1'h1, 32'h0, cfg(1'h1, ocode[i], 4'h0, 4'h0, 1'h0), 1'h0);
         flags <= 9'(1 << obit[i]);
         repeat (3) @(posedge pclk);
         check("oe", 32'h1, {31'h0, gpio_oe});
         check("flag high", 32'h1, {31'h0, gpio_in});
         flags <= ~9'(1 << obit[i]);
         repeat (3) @(posedge pclk);
         check("flag low", 32'h0, {31'h0, gpio_in});
      end
      xfer(1'h1, 32'h0, cfg(1'h1, 4'h1, 4'h0, 4'h0, 1'h1), 1'h0);
      obs(1);
      check("both enables", 32'h0, {31'h0, gpio_oe});
      print_verdict();
   end
endmodule
`default_nettype wire
